// ### inc/acs_pkg.sv
// Package with register map, field layout and timing constants of the converter control block.
package acs_pkg;
    // The control register keeps its printed index; its bus address is that index times four, so word aligned on the bus.
    localparam logic [7:0] ACS_IDX_CTRL = 8'h1F;
    localparam logic [7:0] ACS_ADDR_CTRL = {ACS_IDX_CTRL[5:0], 2'h0};
    localparam logic [7:0] ACS_ADDR_RES_HI = 8'h20;
    localparam logic [7:0] ACS_ADDR_RES_LO = 8'h24;
    localparam logic [7:0] ACS_ADDR_CFG = 8'h28;
    localparam logic [7:0] ACS_ADDR_STAT = 8'h2C;
    localparam logic [7:0] ACS_ADDR_IRQ_ST = 8'h30;
    localparam logic [7:0] ACS_ADDR_IRQ_MASK = 8'h34;
    localparam int ACS_BIT_JUSTIFY = 7;
    localparam int ACS_BIT_REF = 6;
    localparam int ACS_BIT_CH_HI = 3;
    localparam int ACS_BIT_CH_LO = 2;
    localparam int ACS_BIT_START = 1;
    localparam int ACS_BIT_ON = 0;
    localparam logic [7:0] ACS_CTRL_MASK = 8'hCF;
    localparam logic [7:0] ACS_CTRL_RESET = 8'h00;
    localparam int ACS_BIT_CFG_RC = 0;
    localparam int ACS_BIT_CFG_IE = 1;
    localparam logic [1:0] ACS_CFG_RESET = 2'h0;
    localparam int ACS_IRQ_DONE = 0;
    localparam int ACS_IRQ_ABORT = 1;
    localparam int ACS_IRQ_W = 2;
    localparam int ACS_CLK_PERIOD_NS = 4;
    localparam int ACS_INSTR_NS = 16;
    localparam int ACS_INSTR_CYC = (ACS_INSTR_NS + ACS_CLK_PERIOD_NS - 1) / ACS_CLK_PERIOD_NS;
    localparam int ACS_CONV_CYC = 44;
    typedef enum logic [1:0] {
        ACS_IDLE = 2'b00,
        ACS_DELAY = 2'b01,
        ACS_CONV = 2'b10
    } acs_state_t;
endpackage : acs_pkg

// ### design/acs_sync.sv
// Three-stage input synchroniser; a change counts once stages two and three agree.
`timescale 1ns/10ps
`default_nettype none
module acs_sync (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic d_i,
    output logic q_o
);
    logic [2:0] sh_reg;
    logic [2:0] sh_next;
    logic q_reg;
    logic q_next;
    always_comb begin
        sh_next = {sh_reg[1:0], d_i};
        q_next = (sh_reg[1] == sh_reg[2]) ? sh_reg[2] : q_reg;
    end
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sh_reg <= 3'h0;
            q_reg <= 1'b0;
        end else begin
            sh_reg <= sh_next;
            q_reg <= q_next;
        end
    end
    assign q_o = q_reg;
endmodule : acs_sync
`default_nettype wire

// ### design/acs_ctrl.sv
// Converter control register, halt handling and AXI4-Lite slave.
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module acs_ctrl
    import acs_pkg::*;
#(
    parameter int RES_W = 10,
    parameter int CONV_CYC = ACS_CONV_CYC
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic halt_i,
    input wire logic [RES_W-1:0] sample_i,
    output logic [1:0] channel_select_o,
    output logic reference_select_o,
    output logic converter_power_o,
    output logic sampling_o,
    output logic wake_o,
    output logic irq_o
);
    logic halt_s;
    acs_sync u_halt_sync (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .d_i(halt_i),
        .q_o(halt_s)
    );

    logic [7:0] ctrl_reg, ctrl_next;
    logic [1:0] cfg_reg, cfg_next;
    logic [7:0] res_hi_reg, res_hi_next;
    logic [7:0] res_lo_reg, res_lo_next;
    logic pwr_down_reg, pwr_down_next;
    logic wake_reg, wake_next;
    logic [ACS_IRQ_W-1:0] ist_reg, ist_next, imask_reg, imask_next;
    acs_state_t st_reg, st_next;
    logic [15:0] cnt_reg, cnt_next;
    logic [7:0] awaddr_reg, awaddr_next;
    logic aw_reg, aw_next, w_reg, w_next, bvalid_reg, bvalid_next;
    logic [31:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
    logic [3:0] wstrb_reg, wstrb_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic rvalid_reg, rvalid_next;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == ACS_ADDR_CTRL) || (a == ACS_ADDR_RES_HI) || (a == ACS_ADDR_RES_LO)
            || (a == ACS_ADDR_CFG) || (a == ACS_ADDR_STAT) || (a == ACS_ADDR_IRQ_ST)
            || (a == ACS_ADDR_IRQ_MASK);
    endfunction : mapped

    logic do_wr;
    logic [RES_W-1:0] res_w;
    assign do_wr = aw_reg && w_reg && !bvalid_reg;
    assign res_w = sample_i;

    always_comb begin
        aw_next = aw_reg;
        w_next = w_reg;
        awaddr_next = awaddr_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_next = 1'b1;
            awaddr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_next = 1'b1;
            wdata_next = s_axi_wdata;
            wstrb_next = s_axi_wstrb;
        end
        if (do_wr) begin
            aw_next = 1'b0;
            w_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = mapped(awaddr_reg) ? 2'h0 : 2'h2;
        end else if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_next = 1'b1;
            rresp_next = mapped(s_axi_araddr) ? 2'h0 : 2'h2;
            case (s_axi_araddr)
                ACS_ADDR_CTRL: rdata_next = {24'h0, ctrl_reg};
                ACS_ADDR_RES_HI: rdata_next = {24'h0, res_hi_reg};
                ACS_ADDR_RES_LO: rdata_next = {24'h0, res_lo_reg};
                ACS_ADDR_CFG: rdata_next = {30'h0, cfg_reg};
                ACS_ADDR_STAT: rdata_next = {28'h0, halt_s, pwr_down_reg, st_reg};
                ACS_ADDR_IRQ_ST: rdata_next = {30'h0, ist_reg};
                ACS_ADDR_IRQ_MASK: rdata_next = {30'h0, imask_reg};
                default: rdata_next = 32'h0;
            endcase
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
    end

    logic wr_ctrl, done_ev, abort_ev;
    assign wr_ctrl = do_wr && (awaddr_reg == ACS_ADDR_CTRL) && wstrb_reg[0];

    always_comb begin
        ctrl_next = ctrl_reg;
        cfg_next = cfg_reg;
        res_hi_next = res_hi_reg;
        res_lo_next = res_lo_reg;
        pwr_down_next = pwr_down_reg;
        wake_next = 1'b0;
        st_next = st_reg;
        cnt_next = cnt_reg;
        imask_next = imask_reg;
        done_ev = 1'b0;
        abort_ev = 1'b0;
        if (wr_ctrl) begin
            ctrl_next = wdata_reg[7:0] & ACS_CTRL_MASK;
            if (!wdata_reg[ACS_BIT_ON]) begin
                ctrl_next[ACS_BIT_START] = 1'b0;
            end
            if (wdata_reg[ACS_BIT_ON]) begin
                pwr_down_next = 1'b0;
            end
        end
        if (do_wr && awaddr_reg == ACS_ADDR_CFG && wstrb_reg[0]) begin
            cfg_next = wdata_reg[1:0];
        end
        if (do_wr && awaddr_reg == ACS_ADDR_IRQ_MASK && wstrb_reg[0]) begin
            imask_next = wdata_reg[ACS_IRQ_W-1:0];
        end
        if (!halt_s && pwr_down_reg && !ctrl_reg[ACS_BIT_ON]) begin
            pwr_down_next = 1'b0;
        end
        case (st_reg)
            ACS_IDLE: begin
                if (ctrl_next[ACS_BIT_START] && ctrl_next[ACS_BIT_ON] && !pwr_down_next) begin
                    st_next = cfg_reg[ACS_BIT_CFG_RC] ? ACS_DELAY : ACS_CONV;
                    cnt_next = cfg_reg[ACS_BIT_CFG_RC] ? 16'(ACS_INSTR_CYC - 1) : 16'(CONV_CYC - 1);
                end
            end
            ACS_DELAY: begin
                cnt_next = cnt_reg - 16'h1;
                if (cnt_reg == 16'h0) begin
                    st_next = ACS_CONV;
                    cnt_next = 16'(CONV_CYC - 1);
                end
            end
            ACS_CONV: begin
                cnt_next = cnt_reg - 16'h1;
                if (cnt_reg == 16'h0) begin
                    st_next = ACS_IDLE;
                    ctrl_next[ACS_BIT_START] = 1'b0;
                    done_ev = 1'b1;
                    if (ctrl_reg[ACS_BIT_JUSTIFY]) begin
                        res_hi_next = 8'(res_w >> 8);
                        res_lo_next = res_w[7:0];
                    end else begin
                        res_hi_next = 8'(res_w >> (RES_W - 8));
                        res_lo_next = 8'(res_w << (16 - RES_W));
                    end
                    if (halt_s && cfg_reg[ACS_BIT_CFG_IE]) begin
                        wake_next = 1'b1;
                    end else if (halt_s) begin
                        pwr_down_next = 1'b1;
                    end
                end
            end
            default: st_next = ACS_IDLE;
        endcase
        // RC clock keeps converting in halt.
        if (halt_s && !cfg_reg[ACS_BIT_CFG_RC] && ctrl_reg[ACS_BIT_ON] && !pwr_down_reg) begin
            abort_ev = (st_reg != ACS_IDLE);
            st_next = ACS_IDLE;
            ctrl_next[ACS_BIT_START] = 1'b0;
            pwr_down_next = 1'b1;
        end
        if (!ctrl_next[ACS_BIT_ON]) begin
            st_next = ACS_IDLE;
        end
        // Set wins over a write-one clear.
        ist_next = ist_reg;
        if (do_wr && awaddr_reg == ACS_ADDR_IRQ_ST && wstrb_reg[0]) begin
            ist_next = ist_reg & ~wdata_reg[ACS_IRQ_W-1:0];
        end
        if (done_ev) begin
            ist_next[ACS_IRQ_DONE] = 1'b1;
        end
        if (abort_ev) begin
            ist_next[ACS_IRQ_ABORT] = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_reg <= ACS_CTRL_RESET;
            cfg_reg <= ACS_CFG_RESET;
            pwr_down_reg <= 1'b0;
            wake_reg <= 1'b0;
            st_reg <= ACS_IDLE;
            cnt_reg <= 16'h0;
            ist_reg <= '0;
            imask_reg <= '0;
            aw_reg <= 1'b0;
            w_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= 2'h0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= 2'h0;
        end else begin
            ctrl_reg <= ctrl_next;
            cfg_reg <= cfg_next;
            pwr_down_reg <= pwr_down_next;
            wake_reg <= wake_next;
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            ist_reg <= ist_next;
            imask_reg <= imask_next;
            aw_reg <= aw_next;
            w_reg <= w_next;
            awaddr_reg <= awaddr_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    // The result pair survives reset, so it has no reset branch on purpose.
    always_ff @(posedge clk_i) begin
        res_hi_reg <= res_hi_next;
        res_lo_reg <= res_lo_next;
    end

    assign s_axi_awready = !aw_reg;
    assign s_axi_wready = !w_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign channel_select_o = ctrl_reg[ACS_BIT_CH_HI:ACS_BIT_CH_LO];
    assign reference_select_o = ctrl_reg[ACS_BIT_REF];
    assign converter_power_o = ctrl_reg[ACS_BIT_ON] && !pwr_down_reg;
    assign sampling_o = (st_reg == ACS_CONV);
    assign wake_o = wake_reg;
    assign irq_o = |(ist_reg & imask_reg);
endmodule : acs_ctrl
`default_nettype wire

// ### verif/acs_ctrl_monitor.sv
// Port checker for the converter control block.
`timescale 1ns/10ps
`default_nettype none
module acs_ctrl_monitor
    import acs_pkg::*;
#(
    parameter int RES_W = 10,
    parameter int CONV_CYC = ACS_CONV_CYC
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic halt_i,
    input wire logic converter_power_o,
    input wire logic sampling_o,
    input wire logic wake_o
);
    // Counts the current run of sampling cycles; an abort may end a run early.
    logic [15:0] run_reg;
    logic [15:0] run_next;
    always_comb begin
        run_next = sampling_o ? run_reg + 16'h1 : 16'h0;
    end
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            run_reg <= 16'h0;
        end else begin
            run_reg <= run_next;
        end
    end
    default clocking dcb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    sequence s_ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_err_read;
        s_axi_rvalid && (s_axi_rresp == 2'h2);
    endsequence
    property p_rst_quiet;
        $rose(rstn_i) |-> !converter_power_o && !sampling_o && !wake_o;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active after reset");
    property p_sample_pow;
        sampling_o |-> converter_power_o;
    endproperty
    a_sample_pow: assert property (p_sample_pow) else $error("sampling while unpowered");
    property p_conv_max;
        sampling_o |-> run_reg < CONV_CYC;
    endproperty
    a_conv_max: assert property (p_conv_max) else $error("conversion overran");
    property p_wake_pulse;
        wake_o |=> !wake_o;
    endproperty
    a_wake_pulse: assert property (p_wake_pulse) else $error("wake longer than a cycle");
    property p_wake_kept;
        wake_o |-> converter_power_o && !sampling_o;
    endproperty
    a_wake_kept: assert property (p_wake_kept) else $error("wake without power or mid conversion");
    property p_rd_answer;
        s_ar_taken |=> s_axi_rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
    property p_rd_release;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
    endproperty
    a_rd_release: assert property (p_rd_release) else $error("read answer not released");
    property p_err_zero;
        s_err_read |-> s_axi_rdata == 32'h0;
    endproperty
    a_err_zero: assert property (p_err_zero) else $error("error read not zero");
endmodule : acs_ctrl_monitor
bind acs_ctrl acs_ctrl_monitor #(.RES_W(RES_W), .CONV_CYC(CONV_CYC)) i_mon (
    .clk_i(clk_i), .rstn_i(rstn_i), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .halt_i(halt_i), .converter_power_o(converter_power_o),
    .sampling_o(sampling_o), .wake_o(wake_o));
`default_nettype wire

// ### verif/acs_analog_model.sv
// Behavioural model of the analog channels.
`timescale 1ns/10ps
`default_nettype none
module acs_analog_model (
    input wire logic clk_i,
    input wire logic [1:0] channel_select_i,
    input wire logic reference_select_i,
    input wire logic converter_power_i,
    output logic [9:0] sample_o = 10'h155
);
    // channel and reference code
    // Unpowered the line toggles, so a stale value never passes as a result.
    always_ff @(posedge clk_i) begin
        if (converter_power_i) begin
            sample_o <= {reference_select_i, channel_select_i, 7'h2B};
        end else begin
            sample_o <= ~sample_o;
        end
    end
endmodule : acs_analog_model
`default_nettype wire

// ### verif/tb_acs_ctrl.sv
// Self-checking bench for the converter control block.
`timescale 1ns/10ps
`default_nettype none
module tb_acs_ctrl
    import acs_pkg::*;
;
    localparam int CC = 12;
    logic clk_i = 1'h0;
    logic rstn_i = 1'h0;
    logic halt_i = 1'h0;
    logic [7:0] awaddr = 8'h0;
    logic [7:0] araddr = 8'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'h0;
    logic wvalid = 1'h0;
    logic bready = 1'h0;
    logic arvalid = 1'h0;
    logic rready = 1'h0;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, wake, irq, pwr, smp, refs;
    logic [1:0] bresp, rresp, chs, rr, wb;
    logic [9:0] smpl;
    logic [31:0] rdata, rd;
    int failures = 0;
    int checks_done = 0;
    int cyc = 0;
    int d0, d1;
    acs_ctrl #(.CONV_CYC(CC)) i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .halt_i(halt_i),
        .sample_i(smpl), .channel_select_o(chs), .reference_select_o(refs),
        .converter_power_o(pwr), .sampling_o(smp), .wake_o(wake), .irq_o(irq));
    acs_analog_model i_ana (.clk_i(clk_i), .channel_select_i(chs), .reference_select_i(refs),
        .converter_power_i(pwr), .sample_o(smpl));
    always #2 clk_i = ~clk_i;
    task automatic wrap_up;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up
    // A hang is cut short here and counted as a mismatch.
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            wrap_up();
        end
    end
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge clk_i);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (awvalid || wvalid || !bvalid);
        wb = bresp;
        bready <= 1'h0;
    endtask : wr
    task automatic rdr(input logic [7:0] a);
        @(posedge clk_i);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge clk_i);
            if (arready) arvalid <= 1'h0;
        end while (!rvalid);
        rd = rdata;
        rr = rresp;
        rready <= 1'h0;
    endtask : rdr
    task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
        rdr(a);
        chk(n, rd, e);
    endtask : rc
    task automatic conv(input logic [7:0] cf, input logic [7:0] ct, input logic [31:0] hi,
            input logic [31:0] lo, output int d);
        int n;
        n = 0;
        d = 0;
        wr(ACS_ADDR_CFG, {24'h0, cf});
        wr(ACS_ADDR_CTRL, {24'h0, ct});
        while (smp !== 1'h1) begin
            @(posedge clk_i);
            d++;
        end
        while (smp === 1'h1) begin
            @(posedge clk_i);
            n++;
        end
        chk("conv len", n, CC);
        rc("ctrl", ACS_ADDR_CTRL, {24'h0, ct & 8'hFD});
        rc("hi", ACS_ADDR_RES_HI, hi);
        rc("lo", ACS_ADDR_RES_LO, lo);
        rc("done", ACS_ADDR_IRQ_ST, 32'h1);
        wr(ACS_ADDR_IRQ_ST, 32'h1);
        rc("cleared", ACS_ADDR_IRQ_ST, 32'h0);
        $display("conversion test done");
    endtask : conv
    task automatic t_regs;
        rc("ctrl rst", ACS_ADDR_CTRL, 32'h0);
        rdr(8'h3C);
        chk("unmapped", rr, 2'h2);
        wr(8'h3C, 32'h0);
        chk("wr unmapped", wb, 2'h2);
        wr(ACS_ADDR_CTRL, 32'hF9);
        chk("wr ok", wb, 2'h0);
        rc("fields", ACS_ADDR_CTRL, 32'hC9);
        chk("chan", chs, 2'h2);
        chk("ref", refs, 1'h1);
        chk("power", pwr, 1'h1);
        wstrb <= 4'hE;
        wr(ACS_ADDR_CTRL, 32'h0);
        wstrb <= 4'hF;
        rc("lane0 only", ACS_ADDR_CTRL, 32'hC9);
        $display("register test done");
    endtask : t_regs
    task automatic t_wake;
        wr(ACS_ADDR_IRQ_MASK, 32'h1);
        wr(ACS_ADDR_CFG, 32'h3);
        wr(ACS_ADDR_CTRL, 32'h7);
        halt_i <= 1'h1;
        do @(posedge clk_i); while (wake !== 1'h1);
        chk("irq", irq, 1'h1);
        chk("power", pwr, 1'h1);
        halt_i <= 1'h0;
        wr(ACS_ADDR_IRQ_ST, 32'h1);
        chk("irq clr", irq, 1'h0);
        wr(ACS_ADDR_IRQ_MASK, 32'h0);
        $display("wake test done");
    endtask : t_wake
    task automatic t_sleep_off;
        wr(ACS_ADDR_CFG, 32'h1);
        wr(ACS_ADDR_CTRL, 32'h7);
        halt_i <= 1'h1;
        do @(posedge clk_i); while (smp !== 1'h1);
        do @(posedge clk_i); while (smp === 1'h1);
        repeat (2) @(posedge clk_i);
        chk("power", pwr, 1'h0);
        chk("masked irq", irq, 1'h0);
        rc("on kept", ACS_ADDR_CTRL, 32'h5);
        rc("hi", ACS_ADDR_RES_HI, 32'h2A);
        wr(ACS_ADDR_IRQ_ST, 32'h1);
        halt_i <= 1'h0;
        repeat (6) @(posedge clk_i);
        $display("halt power-down test done");
    endtask : t_sleep_off
    task automatic t_abort;
        wr(ACS_ADDR_CFG, 32'h0);
        wr(ACS_ADDR_CTRL, 32'h3);
        do @(posedge clk_i); while (smp !== 1'h1);
        halt_i <= 1'h1;
        do @(posedge clk_i); while (smp === 1'h1);
        chk("power", pwr, 1'h0);
        rc("abort", ACS_ADDR_IRQ_ST, 32'h2);
        rc("on kept", ACS_ADDR_CTRL, 32'h1);
        rc("stat", ACS_ADDR_STAT, 32'hC);
        halt_i <= 1'h0;
        wr(ACS_ADDR_IRQ_ST, 32'h3);
        repeat (6) @(posedge clk_i);
        $display("abort test done");
    endtask : t_abort
    task automatic t_reset_mid;
        wr(ACS_ADDR_CTRL, 32'h3);
        do @(posedge clk_i); while (smp !== 1'h1);
        rstn_i <= 1'h0;
        repeat (3) @(posedge clk_i);
        chk("smp", smp, 1'h0);
        chk("power", pwr, 1'h0);
        rstn_i <= 1'h1;
        rc("ctrl", ACS_ADDR_CTRL, 32'h0);
        rc("lo kept", ACS_ADDR_RES_LO, 32'hC0);
        $display("reset test done");
    endtask : t_reset_mid
    initial begin
        repeat (3) @(posedge clk_i);
        rstn_i <= 1'h1;
        t_regs();
        conv(8'h0, 8'hCB, 32'h3, 32'h2B, d0);
        conv(8'h1, 8'h07, 32'h2A, 32'hC0, d1);
        chk("rc delay", d1 - d0, ACS_INSTR_CYC);
        t_wake();
        t_sleep_off();
        t_abort();
        t_reset_mid();
        wrap_up();
    end
endmodule : tb_acs_ctrl
`default_nettype wire
